// ==== rtl/scan_trigger_regs.vh ====
// register offsets, field layouts, encodings and timing counts
`ifndef SCAN_TRIGGER_REGS_VH
`define SCAN_TRIGGER_REGS_VH

`define OFF_CTRL        12'h000
`define OFF_ROUTE       12'h004
`define OFF_CMD         12'h008
`define OFF_STATUS      12'h00C
`define OFF_PULSE       12'h010

// control register fields
`define CTRL_ENABLE_BIT     0
`define CTRL_IN_EDGE_BIT    1
`define CTRL_OUT_EDGE_BIT   2
`define CTRL_MODE_LSB       4
`define CTRL_MODE_MSB       5

// route register fields
`define ROUTE_SRC_LSB       0
`define ROUTE_SRC_MSB       5
`define ROUTE_DST_LSB       8
`define ROUTE_DST_MSB       13

// command register bits
`define CMD_SW_TRIG_BIT     0
`define CMD_STEP_BIT        1
`define CMD_STEP_WAIT_BIT   2
`define CMD_ABORT_BIT       3

// connection order modes
`define MODE_NEUTRAL        2'h0
`define MODE_OPEN_FIRST     2'h1
`define MODE_CLOSE_FIRST    2'h2

// advance source codes
`define SRC_IMMEDIATE       6'h00
`define SRC_EXTERNAL        6'h01
`define SRC_SOFTWARE        6'h02
`define SRC_LINE0           6'h03
`define SRC_STAR            6'h0B
`define SRC_REAR            6'h0C
`define SRC_FRONT           6'h0D
`define SRC_REAR_MOD1       6'h0E
`define SRC_FRONT_MOD1      6'h1A

// step-done destination codes
`define DST_NONE            6'h00
`define DST_EXTERNAL        6'h01
`define DST_LINE0           6'h03
`define DST_STAR            6'h0B
`define DST_REAR            6'h0C
`define DST_FRONT           6'h0D
`define DST_REAR_MOD1       6'h0E
`define DST_FRONT_MOD1      6'h1A

// number of trigger pins: ext, 8 lines, star, rear, front, 12+12 modules, plus one unused pin
`define NUM_PINS            37
`define PIN_EXT             0
`define PIN_LINE0           1
`define PIN_STAR            9
`define PIN_REAR            10
`define PIN_FRONT           11
`define PIN_REAR_MOD1       12
`define PIN_FRONT_MOD1      24

// timing
`define SETTLE_NS           1000
`define CLK_NS              8
`define SETTLE_CYC          ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define PULSE_DEF_CYC       16'h0008
`define CTRL_RESET          32'h0000_0000
`define ROUTE_RESET         32'h0000_0000

`endif

// ==== rtl/scan_trigger_router.v ====
// scan-step trigger routing, step sequencing and apb register file
`timescale 1ns/1ps
`include "scan_trigger_regs.vh"

module scan_trigger_router (
  input  wire                 clk_sys,
  input  wire                 rstn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire [`NUM_PINS-1:0] trig_pin_in,
  output reg  [`NUM_PINS-1:0] trig_pin_out,
  output reg  [`NUM_PINS-1:0] trig_pin_oe,
  output reg                  open_old_req,
  output reg                  close_new_req,
  input  wire                 relay_done,
  output reg                  entry_advance
);

  localparam [6:0] ST_IDLE   = 7'b0000001;
  localparam [6:0] ST_WAIT   = 7'b0000010;
  localparam [6:0] ST_FIRST  = 7'b0000100;
  localparam [6:0] ST_SECOND = 7'b0001000;
  localparam [6:0] ST_SETTLE = 7'b0010000;
  localparam [6:0] ST_PULSE  = 7'b0100000;
  localparam [6:0] ST_DONE   = 7'b1000000;
  localparam integer SETTLE_INT    = `SETTLE_CYC;
  localparam integer PIN_LINE0_INT = `PIN_LINE0;
  localparam integer PIN_STAR_INT  = `PIN_STAR;
  localparam [15:0]  SETTLE_CNT    = SETTLE_INT[15:0];
  localparam [5:0]   PIN_LINE0_IDX = PIN_LINE0_INT[5:0];
  localparam [5:0]   PIN_STAR_IDX  = PIN_STAR_INT[5:0];

  reg  [31:0] ctrl_q;
  reg  [31:0] route_q;
  reg  [15:0] pulse_len_q;
  reg  [6:0]  state_q;
  reg  [15:0] cnt_q;
  reg         sw_trig_q;
  reg         step_req_q;
  reg         step_wait_q;
  reg  [5:0]  dst_lat_q;
  reg         out_edge_q;
  reg  [31:0] entries_q;
  wire [`NUM_PINS-1:0] edge_seen;
  wire [5:0]  src_sel = route_q[`ROUTE_SRC_MSB:`ROUTE_SRC_LSB];
  wire [5:0]  dst_sel = route_q[`ROUTE_DST_MSB:`ROUTE_DST_LSB];
  wire [1:0]  order_mode = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire        wr_en = psel & penable & pwrite;
  wire        rd_en = psel & penable & ~pwrite;
  wire        hit;
  wire        cmd_wr = wr_en & (paddr == `OFF_CMD);

  assign pready  = 1'b1;
  assign hit     = (paddr == `OFF_CTRL) | (paddr == `OFF_ROUTE) |
                   (paddr == `OFF_CMD) | (paddr == `OFF_STATUS) |
                   (paddr == `OFF_PULSE);
  assign pslverr = psel & penable & ~hit;

  // maps a source or destination code to a pin index, 63 when none
  function [5:0] code_to_pin;
    input [5:0] code;
    begin
      if (code == `SRC_EXTERNAL)
        code_to_pin = `PIN_EXT;
      else if (code >= `SRC_LINE0 && code < `SRC_STAR)
        code_to_pin = code - `SRC_LINE0 + PIN_LINE0_IDX;
      else if (code >= `SRC_STAR && code < `SRC_FRONT_MOD1 + 6'h0C)
        code_to_pin = code - `SRC_STAR + PIN_STAR_IDX;
      else
        code_to_pin = 6'h3F;
    end
  endfunction

  // sync on every pin, edge polarity from input edge select
  trig_pin_sync u_sync (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .pin_in      (trig_pin_in),
    .falling_sel (ctrl_q[`CTRL_IN_EDGE_BIT]),
    .edge_seen   (edge_seen)
  );

  wire [5:0] src_pin = code_to_pin(src_sel);
  wire [5:0] dst_pin = code_to_pin(dst_sel);
  reg        trig_hit;

  always @* begin
    if (src_sel == `SRC_IMMEDIATE)
      trig_hit = 1'b1;
    else if (src_sel == `SRC_SOFTWARE)
      trig_hit = sw_trig_q;
    else if (src_pin != 6'h3F)
      trig_hit = edge_seen[src_pin];
    else
      trig_hit = 1'b0;
  end

  // registers and apb
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_q      <= `CTRL_RESET;
      route_q     <= `ROUTE_RESET;
      pulse_len_q <= `PULSE_DEF_CYC;
    end else if (wr_en) begin
      case (paddr)
        `OFF_CTRL:  ctrl_q      <= pwdata;
        `OFF_ROUTE: route_q     <= pwdata;
        `OFF_PULSE: pulse_len_q <= (pwdata[15:0] == 16'h0000) ?
                                   16'h0001 : pwdata[15:0];
        default:    ctrl_q      <= ctrl_q;
      endcase
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        `OFF_CTRL:   prdata = {26'h0, ctrl_q[5:4], 1'b0, ctrl_q[2:0]};
        `OFF_ROUTE:  prdata = {18'h0, route_q[13:8], 2'h0, route_q[5:0]};
        `OFF_STATUS: prdata = {entries_q[15:0], 8'h0, 1'b0, state_q};
        `OFF_PULSE:  prdata = {16'h0, pulse_len_q};
        default:     prdata = 32'h0000_0000;
      endcase
    end
  end

  // step sequencer
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q       <= ST_IDLE;
      cnt_q         <= 16'h0000;
      sw_trig_q     <= 1'b0;
      step_req_q    <= 1'b0;
      step_wait_q   <= 1'b0;
      dst_lat_q     <= `DST_NONE;
      out_edge_q    <= 1'b0;
      entries_q     <= 32'h0000_0000;
      open_old_req  <= 1'b0;
      close_new_req <= 1'b0;
      entry_advance <= 1'b0;
      trig_pin_out  <= {`NUM_PINS{1'b0}};
      trig_pin_oe   <= {`NUM_PINS{1'b0}};
    end else begin
      entry_advance <= 1'b0;
      // trigger pending set wins over its consumption
      if (cmd_wr && pwdata[`CMD_SW_TRIG_BIT])
        sw_trig_q <= 1'b1;
      else if (state_q != ST_WAIT || trig_hit)
        sw_trig_q <= 1'b0;
      if (cmd_wr && pwdata[`CMD_STEP_BIT]) begin
        step_req_q  <= 1'b1;
        step_wait_q <= pwdata[`CMD_STEP_WAIT_BIT];
      end
      if (cmd_wr && pwdata[`CMD_ABORT_BIT]) begin
        state_q       <= ST_IDLE;
        step_req_q    <= 1'b0;
        open_old_req  <= 1'b0;
        close_new_req <= 1'b0;
        trig_pin_oe   <= {`NUM_PINS{1'b0}};
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (step_req_q && ctrl_q[`CTRL_ENABLE_BIT]) begin
              step_req_q <= 1'b0;
              // wait only at a separator step
              state_q <= step_wait_q ? ST_WAIT : ST_FIRST;
            end
          end
          ST_WAIT: begin
            if (trig_hit)
              state_q <= ST_FIRST;
          end
          ST_FIRST: begin
            entry_advance <= 1'b1;
            if (order_mode == `MODE_OPEN_FIRST)
              open_old_req <= 1'b1;
            else if (order_mode == `MODE_CLOSE_FIRST)
              close_new_req <= 1'b1;
            state_q <= (order_mode == `MODE_NEUTRAL) ? ST_SECOND : ST_SECOND;
          end
          ST_SECOND: begin
            if (order_mode == `MODE_NEUTRAL) begin
              state_q <= ST_SETTLE;
              cnt_q   <= SETTLE_CNT;
            end else if (relay_done) begin
              open_old_req  <= order_mode == `MODE_CLOSE_FIRST;
              close_new_req <= order_mode == `MODE_OPEN_FIRST;
              state_q <= ST_SETTLE;
              cnt_q   <= SETTLE_CNT;
            end
          end
          ST_SETTLE: begin
            if (open_old_req || close_new_req) begin
              if (relay_done) begin
                open_old_req  <= 1'b0;
                close_new_req <= 1'b0;
              end
            end else if (cnt_q > 16'h0001) begin
              cnt_q <= cnt_q - 16'h0001;
            end else begin
              dst_lat_q  <= dst_sel;
              out_edge_q <= ctrl_q[`CTRL_OUT_EDGE_BIT];
              cnt_q      <= pulse_len_q;
              state_q    <= ST_PULSE;
              if (dst_pin != 6'h3F) begin
                trig_pin_oe[dst_pin]  <= 1'b1;
                // falling edge selected: pulse drives the pin low, pin released (oe low, out 0) outside the pulse
                trig_pin_out[dst_pin] <= ~ctrl_q[`CTRL_OUT_EDGE_BIT];
              end
            end
          end
          ST_PULSE: begin
            if (cnt_q > 16'h0001) begin
              cnt_q <= cnt_q - 16'h0001;
            end else begin
              trig_pin_out <= {`NUM_PINS{1'b0}};
              trig_pin_oe  <= {`NUM_PINS{1'b0}};
              state_q      <= ST_DONE;
            end
          end
          ST_DONE: begin
            entries_q <= entries_q + 32'h0000_0001;
            state_q   <= ST_IDLE;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// ==== rtl/trig_pin_sync.v ====
// two-stage synchronisers and edge detection for all trigger pins
`timescale 1ns/1ps
`include "scan_trigger_regs.vh"

module trig_pin_sync (
  input  wire                  clk_sys,
  input  wire                  rstn,
  input  wire [`NUM_PINS-1:0]  pin_in,
  input  wire                  falling_sel,
  output reg  [`NUM_PINS-1:0]  edge_seen
);

  reg [`NUM_PINS-1:0] meta_q;
  reg [`NUM_PINS-1:0] sync_q;
  reg [`NUM_PINS-1:0] prev_q;

  genvar i;
  generate
    for (i = 0; i < `NUM_PINS; i = i + 1) begin : g_pin
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          meta_q[i]    <= 1'b0;
          sync_q[i]    <= 1'b0;
          prev_q[i]    <= 1'b0;
          edge_seen[i] <= 1'b0;
        end else begin
          meta_q[i]    <= pin_in[i];
          sync_q[i]    <= meta_q[i];
          prev_q[i]    <= sync_q[i];
          edge_seen[i] <= falling_sel ? (prev_q[i] & ~sync_q[i])
                                      : (~prev_q[i] & sync_q[i]);
        end
      end
    end
  endgenerate

endmodule

// ==== test/scan_instrument_model.sv ====
// far side model: relay driver answers and instrument trigger pins
`timescale 1ns/1ps
`include "scan_trigger_regs.vh"

module scan_instrument_model #(
  parameter int DLY = 5
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 open_old_req,
  input  wire logic                 close_new_req,
  output logic                      relay_done,
  output logic [`NUM_PINS-1:0]      trig_pin_in
);
  int cnt;
  initial trig_pin_in = '0;
  // relays finish DLY+1 cycles after a request is raised
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      relay_done <= 1'b0;
    end else begin
      relay_done <= 1'b0;
      if ((open_old_req || close_new_req) && !relay_done) begin
        cnt <= (cnt == DLY) ? 0 : cnt + 1;
        relay_done <= (cnt == DLY);
      end
    end
  end
  // a high pulse gives both a rising and a falling edge
  task automatic pulse(input int k);
    @(posedge clk_sys);
    trig_pin_in[k] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    trig_pin_in[k] <= 1'b0;
  endtask
endmodule

// ==== test/scan_trigger_router_assertions.sv ====
// concurrent checks on the scan trigger router ports
`timescale 1ns/1ps
`include "scan_trigger_regs.vh"

module scan_trigger_router_checker (
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [`NUM_PINS-1:0] trig_pin_in,
  input wire logic [`NUM_PINS-1:0] trig_pin_out,
  input wire logic [`NUM_PINS-1:0] trig_pin_oe,
  input wire logic                 open_old_req,
  input wire logic                 close_new_req,
  input wire logic                 relay_done,
  input wire logic                 entry_advance
);
  logic [1:0]           mode_q;
  logic                 oedge_q;
  logic [5:0]           dst_q;
  logic [15:0]          len_q;
  logic [15:0]          on_q;
  logic [`NUM_PINS-1:0] exp_oe;
  // shadow of the configuration written over the bus
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_q <= 2'h0;
      oedge_q <= 1'b0;
      dst_q <= 6'h00;
      len_q <= `PULSE_DEF_CYC;
      on_q <= 16'h0000;
    end else begin
      on_q <= (|trig_pin_oe) ? on_q + 16'h0001 : 16'h0000;
      if (psel && penable && pwrite && paddr == `OFF_CTRL) begin
        mode_q <= pwdata[5:4];
        oedge_q <= pwdata[2];
      end
      if (psel && penable && pwrite && paddr == `OFF_ROUTE)
        dst_q <= pwdata[13:8];
      if (psel && penable && pwrite && paddr == `OFF_PULSE)
        len_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
    end
  end
  always_comb begin
    exp_oe = '0;
    if (dst_q == 6'h01)
      exp_oe[0] = 1'b1;
    else if (dst_q >= 6'h03 && dst_q <= 6'h25)
      exp_oe[dst_q - 6'h02] = 1'b1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_unmapped_err: assert property
    (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access without pslverr");
  chk_neutral_idle: assert property
    (mode_q == 2'h0 |-> !open_old_req && !close_new_req)
    else $error("relay request in neutral mode");
  chk_open_before_close: assert property
    (mode_q == 2'h1 && $rose(close_new_req) |-> $past(open_old_req))
    else $error("close before open in open-first mode");
  chk_close_before_open: assert property
    (mode_q == 2'h2 && $rose(open_old_req) |-> $past(close_new_req))
    else $error("open before close in close-first mode");
  chk_dest_pin_map: assert property
    (|trig_pin_oe |-> trig_pin_oe == exp_oe)
    else $error("step-done driven on wrong pin");
  chk_out_edge_level: assert property
    (|trig_pin_oe |->
     (trig_pin_out & trig_pin_oe) == (oedge_q ? '0 : trig_pin_oe))
    else $error("step-done pulse level wrong");
  chk_pulse_length: assert property
    ($fell(|trig_pin_oe) |-> on_q == len_q)
    else $error("step-done pulse length wrong");
  chk_advance_single: assert property
    (entry_advance |=> !entry_advance ##1 !entry_advance)
    else $error("entry advance not a single pulse");
  chk_pulse_before_step: assert property
    (entry_advance |-> !(|trig_pin_oe))
    else $error("entry advanced during step-done pulse");
  cover property ($fell(|trig_pin_oe));
  cover property (mode_q == 2'h1 && $rose(close_new_req));
  cover property (mode_q == 2'h2 && $rose(open_old_req));
endmodule

// ==== test/scan_trigger_router_tb.sv ====
// self-checking bench for the scan trigger router
`timescale 1ns/1ps
`include "scan_trigger_regs.vh"

module scan_trigger_router_tb;
  logic                 clk_sys, rstn, psel, penable, pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  logic                 pready, pslverr, relay_done, entry_advance;
  logic                 open_old_req, close_new_req, err;
  logic [`NUM_PINS-1:0] trig_pin_in, trig_pin_out, trig_pin_oe, oe_acc;
  int                   n_fail, comparisons, n_step, on_n, i, t;
  int                   dst[11] = '{0, 1, 3, 10, 11, 12, 13, 14, 25, 26, 37};
  int                   src[11] = '{1, 2, 3, 10, 11, 12, 13, 14, 25, 26, 37};

  scan_trigger_router dut (.*);
  scan_instrument_model p (.*);

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    oe_acc |= trig_pin_oe;
    if (|trig_pin_oe) on_n++;
  end

  task automatic apb(input logic        w,
                     input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [63:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_step;
    n_step++;
    t = 0;
    do begin
      apb(1'b0, `OFF_STATUS, 32'h0);
      t++;
    end while (rd[31:16] !== n_step[15:0] && t < 300);
    chk("step_count", rd[31:16], n_step);
  endtask

  function automatic logic [63:0] pin_of(input int c);
    pin_of = 64'h0;
    if (c == 1) pin_of[0] = 1'b1;
    else if (c >= 3) pin_of[c - 2] = 1'b1;
  endfunction

  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    end_of_test;
  end

  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    comparisons = 0;
    n_step = 0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    apb(1'b0, `OFF_PULSE, 32'h0);
    chk("pulse_reset", rd, 64'h8);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", err, 64'h1);
    apb(1'b1, `OFF_PULSE, 32'h3);
    for (i = 0; i < 11; i++) begin
      apb(1'b1, `OFF_CTRL,
          32'h1 | ((i % 3) << 4) | ((i % 2) << 2));
      apb(1'b1, `OFF_ROUTE, dst[i] << 8);
      oe_acc = '0;
      on_n = 0;
      apb(1'b1, `OFF_CMD, 32'h2);
      wait_step;
      chk("dest_pins", oe_acc, pin_of(dst[i]));
      chk("pulse_cycles", on_n, (dst[i] == 0) ? 0 : 3);
    end
    for (i = 0; i < 11; i++) begin
      apb(1'b1, `OFF_CTRL, 32'h1 | ((i % 2) << 1));
      apb(1'b1, `OFF_ROUTE, src[i]);
      apb(1'b1, `OFF_CMD, 32'h6);
      repeat (40) @(posedge clk_sys);
      apb(1'b0, `OFF_STATUS, 32'h0);
      chk("held_count", rd[31:16], n_step);
      if (src[i] == 2) apb(1'b1, `OFF_CMD, 32'h1);
      else p.pulse(src[i] == 1 ? 0 : src[i] - 2);
      wait_step;
    end
    // abort while waiting for a trigger returns to idle without a step
    apb(1'b1, `OFF_CMD, 32'h6);
    repeat (4) @(posedge clk_sys);
    apb(1'b1, `OFF_CMD, 32'h8);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk("abort_state", rd[6:0], 64'h1);
    chk("abort_count", rd[31:16], n_step);
    apb(1'b1, `OFF_CMD, 32'h2);
    wait_step;
    end_of_test;
  end
endmodule

bind scan_trigger_router scan_trigger_router_checker chk_i (.*);
